// ==== hdl/tcc_pkg.sv ====
// Purpose: constants and types for the timer capture/compare block
// Assumes: 8-bit register port, 16-bit timer counter outside
// Notes:   byte offsets are register indexes on the plain port
package tcc_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] CAP_LO   = 4'h0;
  localparam logic [3:0] CAP_HI   = 4'h1;
  localparam logic [3:0] CMPA_LO  = 4'h2;
  localparam logic [3:0] CMPA_HI  = 4'h3;
  localparam logic [3:0] CMPB_LO  = 4'h4;
  localparam logic [3:0] CMPB_HI  = 4'h5;
  localparam logic [3:0] CNT_LO   = 4'h6;
  localparam logic [3:0] CNT_HI   = 4'h7;
  localparam logic [3:0] CTRL_A   = 4'h8;
  localparam logic [3:0] CTRL_B   = 4'h9;
  localparam logic [3:0] OUT_MODE = 4'ha;
  localparam logic [3:0] IRQ_EN   = 4'hb;
  localparam logic [3:0] FLAGS    = 4'hc;
  // ****************************************
  // field positions
  // ****************************************
  localparam int FORCE_A_BIT = 4;  // ctrl_a, write only
  localparam int FORCE_B_BIT = 5;
  localparam int EDGE_BIT    = 0;  // ctrl_b
  localparam int FILT_BIT    = 1;
  localparam int SRC_BIT     = 2;
  localparam int CAP_BIT     = 0;  // irq_en and flags
  localparam int CMPA_BIT    = 1;
  localparam int CMPB_BIT    = 2;
  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam int          FILT_LEN = 4;  // agreeing samples
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [3:0] wgm;        // waveform mode
    logic       edge_rise;  // capture polarity
    logic       filt_en;    // noise filter
    logic       src_comp;   // comparator as source
    logic [1:0] com_a;      // output mode a
    logic [1:0] com_b;      // output mode b
  } tcc_ctrl_t;
  typedef struct packed {
    logic tick;    // timer clock enable
    logic at_top;  // counter at top
    logic at_bot;  // counter at bottom
  } tcc_cnt_t;
endpackage

// ==== hdl/tcc_top.sv ====
// Purpose: input capture and two output compare channels
// Assumes: counter sequencing and prescaler live outside
// Notes:   one clock, timer rate arrives as a tick enable
//
// What this block does
// - capture on edge matching chosen polarity
// - capture copies full 16-bit counter
// - capture flag set with the copy
// - capture flag plus enable raises interrupt
// - capture flag cleared by service or one
// - low read latches high byte for later
// - capture register writable only in top modes
// - pin by default, comparator when selected
// - filter output changes after four agreeing samples
// - filter adds four clock cycles latency
// - filter samples on undivided system clock
// - capture input idle in capture-top modes
// - port-driven pin level triggers like edge
// - new capture overwrites unread value
// - compare flag plus enable raises interrupt
// - compare flag cleared by service or one
// - waveform output follows mode and match
// - channel a can supply counter top
// - compare double buffered only in pwm modes
// - one shared high byte latch
// - buffer loads at top or bottom
// - counter write blocks next-tick match
// - force updates output in non-pwm modes only, no flag
`timescale 1ns/100ps
module tcc_top #(
  parameter int DW = 8,   // register data width
  parameter int CW = 16   // counter width
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // register port
  input  wire logic [3:0]    addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [DW-1:0] rdata,
  // trigger inputs
  input  wire logic          capture_pin,
  input  wire logic          comparator_out,
  // counter interface
  input  wire logic [CW-1:0] counter_value,
  input  wire tcc_pkg::tcc_cnt_t cnt,
  output logic               cnt_wr,
  output logic      [CW-1:0] cnt_wr_data,
  output logic      [CW-1:0] top_value,
  // interrupts and service
  input  wire logic [2:0]    irq_ack,
  output logic               irq_cap,
  output logic               irq_cmp_a,
  output logic               irq_cmp_b,
  // waveform outputs
  output logic               oc_a,
  output logic               oc_b
);
  // ****************************************
  // decode helpers
  // ****************************************
  // capture register defines top in these modes
  function automatic logic cap_is_top(input logic [3:0] m);
    return (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
  endfunction
  // normal and clear-on-match modes are not pwm
  function automatic logic is_pwm(input logic [3:0] m);
    return !((m == 4'h0) || (m == 4'h4) || (m == 4'hc) || (m == 4'hd));
  endfunction
  // channel a defines top in these modes
  function automatic logic cmpa_is_top(input logic [3:0] m);
    return (m == 4'h4) || (m == 4'h9) || (m == 4'hb) || (m == 4'hf);
  endfunction

  // ****************************************
  // state
  // ****************************************
  tcc_pkg::tcc_ctrl_t ctrl;          // control fields
  logic [DW-1:0]      high_latch;    // shared high byte
  logic [CW-1:0]      cap_reg;       // captured stamp
  logic [CW-1:0]      cmp_reg [2];   // active compare
  logic [CW-1:0]      cmp_buf [2];   // buffered compare
  logic [2:0]         irq_en;        // interrupt enables
  logic [2:0]         flag;          // sticky flags
  logic [1:0]         sync_pin;      // pin synchroniser
  logic [1:0]         sync_cmp;      // comparator sync
  logic [tcc_pkg::FILT_LEN-1:0] filt_sh; // sample history
  logic               filt_out;      // filtered level, held
  logic               filt_level;    // filter output this cycle
  logic               det_prev;      // edge history
  logic               block_match;   // set by counter write
  logic               pwm;           // current mode is pwm
  logic               det_in;        // edge detector input
  logic               cap_fire;      // capture this cycle
  logic [2:0]         flag_clr;      // software clear bits
  logic [1:0]         match;         // qualified match
  logic [1:0]         force_hit;     // forced match

  assign pwm = is_pwm(ctrl.wgm);

  // ****************************************
  // trigger path
  // ****************************************
  // both triggers cross into the clock domain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_pin <= 2'h0;
      sync_cmp <= 2'h0;
    end else begin
      sync_pin <= {sync_pin[0], capture_pin};
      sync_cmp <= {sync_cmp[0], comparator_out};
    end
  end

  // filter history runs on every system clock, not the tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      filt_sh  <= '0;
      filt_out <= 1'b0;
    end else begin
      // source mux reads only second flop outputs
      filt_sh <= {filt_sh[tcc_pkg::FILT_LEN-2:0],
                  ctrl.src_comp ? sync_cmp[1] : sync_pin[1]};
      filt_out <= filt_level;
    end
  end

  // level moves in the cycle the fourth agreeing sample lands,
  // so the filter costs exactly four cycles and not five
  always_comb begin
    if (&filt_sh) begin
      filt_level = 1'b1;
    end else if (~|filt_sh) begin
      filt_level = 1'b0;
    end else begin
      filt_level = filt_out;  // mixed samples hold the level
    end
  end

  // bypass keeps the filter out of the latency when off
  always_comb begin
    if (ctrl.filt_en) begin
      det_in = filt_level;
    end else begin
      det_in = ctrl.src_comp ? sync_cmp[1] : sync_pin[1];
    end
  end

  // edge history; frozen while capture register is top
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      det_prev <= 1'b0;
    end else if (!cap_is_top(ctrl.wgm)) begin
      det_prev <= det_in;
    end
  end

  // polarity selects rising or falling edge
  assign cap_fire = !cap_is_top(ctrl.wgm) &&
                    (ctrl.edge_rise ? (det_in && !det_prev)
                                    : (!det_in && det_prev));

  // ****************************************
  // register writes
  // ****************************************
  // control fields and enables
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl   <= '0;
      irq_en <= 3'h0;
    end else if (wr) begin
      case (addr)
        tcc_pkg::CTRL_A: begin
          ctrl.wgm <= wdata[3:0];
        end
        tcc_pkg::CTRL_B: begin
          ctrl.edge_rise <= wdata[tcc_pkg::EDGE_BIT];
          ctrl.filt_en   <= wdata[tcc_pkg::FILT_BIT];
          ctrl.src_comp  <= wdata[tcc_pkg::SRC_BIT];
        end
        tcc_pkg::OUT_MODE: begin
          ctrl.com_a <= wdata[1:0];
          ctrl.com_b <= wdata[3:2];
        end
        tcc_pkg::IRQ_EN: begin
          irq_en <= wdata[2:0];
        end
        default: begin
          // other offsets touch no control
        end
      endcase
    end
  end

  // one latch serves every split access but compare reads
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_latch <= tcc_pkg::CTRL_RST;
    end else if (wr && (addr == tcc_pkg::CAP_HI || addr == tcc_pkg::CMPA_HI ||
                        addr == tcc_pkg::CMPB_HI || addr == tcc_pkg::CNT_HI)) begin
      high_latch <= wdata;
    end else if (rd && addr == tcc_pkg::CAP_LO) begin
      high_latch <= cap_reg[15:8];
    end else if (rd && addr == tcc_pkg::CNT_LO) begin
      high_latch <= counter_value[15:8];
    end
  end

  // capture register: hardware stamp, or top write in top modes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_reg <= tcc_pkg::WORD_RST;
    end else if (cap_fire) begin
      cap_reg <= counter_value;
    end else if (wr && addr == tcc_pkg::CAP_LO && cap_is_top(ctrl.wgm)) begin
      cap_reg <= {high_latch, wdata};
    end
  end

  // compare channels: buffer in pwm, direct otherwise
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    localparam logic [3:0] LO = i ? tcc_pkg::CMPB_LO : tcc_pkg::CMPA_LO;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cmp_buf[i] <= tcc_pkg::WORD_RST;
        cmp_reg[i] <= tcc_pkg::WORD_RST;
      end else begin
        if (wr && addr == LO) begin
          cmp_buf[i] <= {high_latch, wdata};
        end
        if (wr && addr == LO && !pwm) begin
          cmp_reg[i] <= {high_latch, wdata};
        end else if (pwm && cnt.tick && (cnt.at_top || cnt.at_bot)) begin
          cmp_reg[i] <= cmp_buf[i];
        end
      end
    end
  end

  // counter writes leave as a pulse with the joined word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_wr      <= 1'b0;
      cnt_wr_data <= tcc_pkg::WORD_RST;
    end else begin
      cnt_wr <= wr && addr == tcc_pkg::CNT_LO;
      if (wr && addr == tcc_pkg::CNT_LO) begin
        cnt_wr_data <= {high_latch, wdata};
      end
    end
  end

  // block stays armed until a tick passes, even if stopped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      block_match <= 1'b0;
    end else if (wr && addr == tcc_pkg::CNT_LO) begin
      block_match <= 1'b1;
    end else if (cnt.tick) begin
      block_match <= 1'b0;
    end
  end

  // top source for the counter outside
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      top_value <= tcc_pkg::WORD_RST;
    end else if (cap_is_top(ctrl.wgm)) begin
      top_value <= cap_reg;
    end else if (cmpa_is_top(ctrl.wgm)) begin
      top_value <= cmp_reg[0];
    end else begin
      top_value <= 16'hffff;
    end
  end

  // ****************************************
  // flags and interrupts
  // ****************************************
  // one on a flag bit clears it
  assign flag_clr = (wr && addr == tcc_pkg::FLAGS) ? wdata[2:0] : 3'h0;

  // match counts only on a tick not blocked by a write
  for (genvar i = 0; i < 2; i++) begin : g_match
    assign match[i] = cnt.tick && !block_match &&
                      (counter_value == cmp_reg[i]);
    assign force_hit[i] = !pwm && wr && addr == tcc_pkg::CTRL_A &&
                          wdata[tcc_pkg::FORCE_A_BIT + i];
  end

  // set beats clear so no event is lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag <= 3'h0;
    end else begin
      flag <= (flag & ~flag_clr & ~irq_ack)
            | {match, cap_fire};
    end
  end

  // requests follow flags and enables
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_cap   <= 1'b0;
      irq_cmp_a <= 1'b0;
      irq_cmp_b <= 1'b0;
    end else begin
      irq_cap   <= flag[tcc_pkg::CAP_BIT]  && irq_en[tcc_pkg::CAP_BIT];
      irq_cmp_a <= flag[tcc_pkg::CMPA_BIT] && irq_en[tcc_pkg::CMPA_BIT];
      irq_cmp_b <= flag[tcc_pkg::CMPB_BIT] && irq_en[tcc_pkg::CMPB_BIT];
    end
  end

  // ****************************************
  // waveform outputs
  // ****************************************
  // kept simple: toggle/clear/set on match; in pwm, com 2 sets and com 3 clears at bottom
  function automatic logic wave(input logic cur, input logic [1:0] com,
                                input logic hit, input logic p, input logic bot);
    logic r;
    r = cur;
    if (p && bot && com[1]) begin
      r = !com[0];
    end else if (hit) begin
      case (com)
        2'h1:    r = !cur;
        2'h2:    r = 1'b0;
        2'h3:    r = 1'b1;
        default: r = cur;
      endcase
    end
    return r;
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oc_a <= 1'b0;
      oc_b <= 1'b0;
    end else begin
      oc_a <= wave(oc_a, ctrl.com_a, match[0] || force_hit[0], pwm,
                   cnt.tick && cnt.at_bot);
      oc_b <= wave(oc_b, ctrl.com_b, match[1] || force_hit[1], pwm,
                   cnt.tick && cnt.at_bot);
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // compare reads skip the latch; buffer shown in every mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        tcc_pkg::CAP_LO:   rdata <= cap_reg[7:0];
        tcc_pkg::CAP_HI:   rdata <= high_latch;
        tcc_pkg::CMPA_LO:  rdata <= cmp_buf[0][7:0];
        tcc_pkg::CMPA_HI:  rdata <= cmp_buf[0][15:8];
        tcc_pkg::CMPB_LO:  rdata <= cmp_buf[1][7:0];
        tcc_pkg::CMPB_HI:  rdata <= cmp_buf[1][15:8];
        tcc_pkg::CNT_LO:   rdata <= counter_value[7:0];
        tcc_pkg::CNT_HI:   rdata <= high_latch;
        tcc_pkg::CTRL_A:   rdata <= {4'h0, ctrl.wgm};
        tcc_pkg::CTRL_B:   rdata <= {5'h00, ctrl.src_comp, ctrl.filt_en, ctrl.edge_rise};
        tcc_pkg::OUT_MODE: rdata <= {4'h0, ctrl.com_b, ctrl.com_a};
        tcc_pkg::IRQ_EN:   rdata <= {5'h00, irq_en};
        tcc_pkg::FLAGS:    rdata <= {5'h00, flag};
        default:           rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule // tcc_top

// ==== test/tcc_checker.sv ====
// Purpose: port assertions for the capture/compare block
// Assumes: one clock, nrst async active low
// Notes:   bound to every tcc_top instance below
`timescale 1ns/100ps
module tcc_checker #(
  parameter int DW = 8,   // register data width
  parameter int CW = 16   // counter width
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          nrst,
  // register port
  input wire logic [3:0]    addr,
  input wire logic [DW-1:0] wdata,
  input wire logic          wr,
  input wire logic          rd,
  input wire logic [DW-1:0] rdata,
  // triggers and counter
  input wire logic          capture_pin,
  input wire logic          comparator_out,
  input wire logic [CW-1:0] counter_value,
  input wire tcc_pkg::tcc_cnt_t cnt,
  input wire logic          cnt_wr,
  input wire logic [CW-1:0] cnt_wr_data,
  input wire logic [CW-1:0] top_value,
  // service and outputs
  input wire logic [2:0]    irq_ack,
  input wire logic          irq_cap,
  input wire logic          irq_cmp_a,
  input wire logic          irq_cmp_b,
  input wire logic          oc_a,
  input wire logic          oc_b
);
  // ****
  // one domain, so one clocking and one disable
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  cnt_low_a: assert property (rd && addr == tcc_pkg::CNT_LO
    |=> rdata == $past(counter_value[7:0])) else $error("counter low byte wrong");
  // high byte comes from the latch loaded by the low read
  hi_latch_a: assert property (rd && addr == tcc_pkg::CNT_LO
    ##1 rd && addr == tcc_pkg::CNT_HI
    |=> rdata == $past(counter_value[15:8], 2)) else $error("latched high byte wrong");
  cnt_load_a: assert property (wr && addr == tcc_pkg::CNT_HI
    ##1 wr && addr == tcc_pkg::CNT_LO
    |=> cnt_wr && cnt_wr_data == {$past(wdata, 2), $past(wdata)})
    else $error("counter load wrong");
  cnt_only_a: assert property (cnt_wr |-> $past(wr) && $past(addr) == tcc_pkg::CNT_LO)
    else $error("counter load without write");
  // no tick means no new match can win over the service clear
  ack_clear_a: assert property (irq_ack[1] && !cnt.tick |-> ##2 !irq_cmp_a)
    else $error("compare irq kept after service");
  irq_cause_a: assert property ($rose(irq_cmp_a) |-> $past(cnt.tick, 2) || $past(wr, 2))
    else $error("compare irq without cause");
  oc_cause_a: assert property ($changed(oc_a) |-> $past(cnt.tick) || $past(wr))
    else $error("output a moved without cause");
  cover property (irq_cap);
  cover property (irq_cmp_a && oc_a);
  cover property (cnt_wr);
endmodule // tcc_checker

bind tcc_top tcc_checker #(.DW(DW), .CW(CW)) i_chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .capture_pin(capture_pin), .comparator_out(comparator_out), .counter_value(counter_value),
  .cnt(cnt), .cnt_wr(cnt_wr), .cnt_wr_data(cnt_wr_data), .top_value(top_value),
  .irq_ack(irq_ack), .irq_cap(irq_cap), .irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b),
  .oc_a(oc_a), .oc_b(oc_b));

// ==== test/tcc_cnt_model.sv ====
// Purpose: up counter standing beside the capture/compare block
// Assumes: one tick per clock while run is high
// Notes:   wraps at top_value; a load wins over counting
`timescale 1ns/100ps
module tcc_cnt_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // control
  input  wire logic        run,
  input  wire logic        cnt_wr,
  input  wire logic [15:0] cnt_wr_data,
  input  wire logic [15:0] top_value,
  // counter out
  output logic      [15:0] counter_value,
  output tcc_pkg::tcc_cnt_t cnt
);
  logic [15:0] count;  // counter state
  // load has priority so a stopped timer still takes writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 16'h0000;
    end else if (cnt_wr) begin
      count <= cnt_wr_data;
    end else if (run) begin
      count <= (count == top_value) ? 16'h0000 : count + 16'h0001;
    end
  end
  assign counter_value = count;
  assign cnt = '{tick: run, at_top: count == top_value, at_bot: count == 16'h0000};
endmodule // tcc_cnt_model

// ==== test/tcc_top_bench.sv ====
// Purpose: self-checking bench for the capture/compare block
// Assumes: counter model on the far side, 25 MHz clock
// Notes:   every scenario task judges its own results
`timescale 1ns/100ps
module tcc_top_bench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        capture_pin = 1'b0;
  logic        comparator_out = 1'b0;
  logic [15:0] counter_value;
  tcc_pkg::tcc_cnt_t cnt;
  logic        cnt_wr;
  logic [15:0] cnt_wr_data;
  logic [15:0] top_value;
  logic [2:0]  irq_ack = 3'h0;
  logic        irq_cap, irq_cmp_a, irq_cmp_b, oc_a, oc_b;
  logic        run = 1'b0;  // timer clock enable
  int          n_errors = 0;
  int          comparisons = 0;
  always #20 clk = !clk;
  tcc_top i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .capture_pin(capture_pin), .comparator_out(comparator_out),
    .counter_value(counter_value), .cnt(cnt), .cnt_wr(cnt_wr), .cnt_wr_data(cnt_wr_data),
    .top_value(top_value), .irq_ack(irq_ack), .irq_cap(irq_cap), .irq_cmp_a(irq_cmp_a),
    .irq_cmp_b(irq_cmp_b), .oc_a(oc_a), .oc_b(oc_b));
  tcc_cnt_model i_cnt (.clk(clk), .nrst(nrst), .run(run), .cnt_wr(cnt_wr),
    .cnt_wr_data(cnt_wr_data), .top_value(top_value), .counter_value(counter_value),
    .cnt(cnt));
  // ****
  // shared tasks; each starts and ends just after a rising edge
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // high byte first, so the shared latch is loaded before the join
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr <= 1'b1;
    addr <= a + 4'h1;
    wdata <= d[15:8];
    @(posedge clk);
    addr <= a;
    wdata <= d[7:0];
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // low byte first; each byte is taken in the cycle after its strobe
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    addr <= a + 4'h1;
    #1 d[7:0] = rdata;
    @(posedge clk);
    rd <= 1'b0;
    #1 d[15:8] = rdata;
    @(posedge clk);
  endtask
  task automatic stop_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    logic [15:0] got;
    rd16(tcc_pkg::CTRL_A, got);
    chk(got, 16'h0000, "control reset");
    rd16(tcc_pkg::FLAGS, got);
    chk(got, 16'h0000, "flags or unmapped");
    chk(top_value, 16'hffff, "top in normal mode");
  endtask
  // one edge on the chosen input, the other input and the wrong edge ignored
  task automatic t_capture(input logic comp, input logic rise, input logic filt);
    logic [15:0] v0;
    logic [15:0] got;
    wr8(tcc_pkg::CTRL_B, {5'h00, comp, filt, rise});
    capture_pin <= !rise;
    comparator_out <= !rise;
    repeat (10) @(posedge clk);
    wr8(tcc_pkg::FLAGS, 8'h01);
    if (comp) capture_pin <= rise;
    else comparator_out <= rise;
    repeat (10) @(posedge clk);
    chk(16'(irq_cap), 16'h0000, "unselected input captured");
    if (comp) comparator_out <= rise;
    else capture_pin <= rise;
    #1 v0 = counter_value;
    repeat (10) @(posedge clk);
    chk(16'(irq_cap), 16'h0001, "no capture irq");
    rd16(tcc_pkg::CAP_LO, got);
    chk(got, v0 + (filt ? 16'h0006 : 16'h0002), "capture stamp");
    wr8(tcc_pkg::FLAGS, 8'h01);
    if (comp) comparator_out <= !rise;
    else capture_pin <= !rise;
    repeat (10) @(posedge clk);
    chk(16'(irq_cap), 16'h0000, "wrong edge captured");
  endtask
  task automatic t_glitch();
    capture_pin <= 1'b0;
    wr8(tcc_pkg::CTRL_B, 8'h03);
    repeat (10) @(posedge clk);
    wr8(tcc_pkg::FLAGS, 8'h01);
    capture_pin <= 1'b1;
    repeat (3) @(posedge clk);
    capture_pin <= 1'b0;
    repeat (12) @(posedge clk);
    chk(16'(irq_cap), 16'h0000, "short pulse captured");
  endtask
  task automatic t_cap_top();
    logic [15:0] got;
    wr8(tcc_pkg::CTRL_A, 8'h0c);
    wr16(tcc_pkg::CAP_LO, 16'h1234);
    // top register updates on the edge the task returns on
    #1 chk(top_value, 16'h1234, "capture top");
    @(posedge clk);
    capture_pin <= 1'b1;
    repeat (12) @(posedge clk);
    chk(16'(irq_cap), 16'h0000, "capture in top mode");
    capture_pin <= 1'b0;
    repeat (12) @(posedge clk);
    wr8(tcc_pkg::CTRL_A, 8'h00);
    wr16(tcc_pkg::CAP_LO, 16'h5555);
    rd16(tcc_pkg::CAP_LO, got);
    chk(got, 16'h1234, "capture write in normal mode");
  endtask
  task automatic t_compare();
    logic [15:0] got;
    run <= 1'b0;
    wr8(tcc_pkg::OUT_MODE, 8'h0d);
    wr16(tcc_pkg::CMPA_LO, 16'h2000);
    wr16(tcc_pkg::CMPB_LO, 16'h2002);
    wr16(tcc_pkg::CNT_LO, 16'h2000);
    wr8(tcc_pkg::FLAGS, 8'h07);
    rd16(tcc_pkg::CNT_LO, got);
    chk(got, 16'h2000, "counter read");
    run <= 1'b1;
    repeat (8) @(posedge clk);
    chk(16'(irq_cmp_a), 16'h0000, "match after counter write");
    chk(16'(irq_cmp_b), 16'h0001, "no compare b irq");
    chk(16'(oc_b), 16'h0001, "no set on match b");
    run <= 1'b0;
    wr16(tcc_pkg::CNT_LO, 16'h1ffd);
    run <= 1'b1;
    repeat (8) @(posedge clk);
    chk(16'(irq_cmp_a), 16'h0001, "no compare irq");
    chk(16'(oc_a), 16'h0001, "no toggle on match");
    run <= 1'b0;
    irq_ack <= 3'h6;
    @(posedge clk);
    irq_ack <= 3'h0;
    repeat (2) @(posedge clk);
    chk(16'(irq_cmp_a), 16'h0000, "irq kept after service");
    chk(16'(irq_cmp_b), 16'h0000, "irq b kept after service");
    wr8(tcc_pkg::CTRL_A, 8'h10);
    chk(16'(oc_a), 16'h0000, "force did not toggle");
    rd16(tcc_pkg::FLAGS, got);
    chk(got, 16'h0000, "force set a flag");
  endtask
  // pwm keeps a compare write in the buffer until top or bottom
  task automatic t_pwm();
    run <= 1'b0;
    wr8(tcc_pkg::CTRL_A, 8'h01);
    wr16(tcc_pkg::CMPB_LO, 16'h0004);
    wr16(tcc_pkg::CNT_LO, 16'h0002);
    run <= 1'b1;
    repeat (6) @(posedge clk);
    chk(16'(irq_cmp_b), 16'h0000, "pwm write reached active compare");
    run <= 1'b0;
    wr16(tcc_pkg::CNT_LO, 16'hfffe);
    run <= 1'b1;
    repeat (10) @(posedge clk);
    chk(16'(irq_cmp_b), 16'h0001, "buffer not loaded at top or bottom");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    run <= 1'b1;
    wr8(tcc_pkg::IRQ_EN, 8'h07);
    for (int i = 0; i < 8; i++) t_capture(i[2], i[1], i[0]);
    t_glitch();
    t_cap_top();
    t_compare();
    t_pwm();
    stop_test();
  end
  // about eighteen times the expected run length
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
endmodule // tcc_top_bench
